// File: core/lss_buf2.sv
module lss_buf2 #(
    parameter int W = 8
) (
    input  wire logic         core_clk_in,
    input  wire logic         resetn_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    // Two entries: head feeds the output, tail catches a word while head stalls
    logic [W-1:0] head_q, head_d;
    logic [W-1:0] tail_q, tail_d;
    logic [1:0]   cnt_q,  cnt_d;
    logic         push;
    logic         pop;

    assign in_ready_out  = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out  = head_q;
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_comb begin
        head_d = head_q;
        tail_d = tail_q;
        cnt_d  = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
        if (pop) begin
            head_d = (cnt_q == 2'h2) ? tail_q : in_data_in;
        end
        if (push) begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
                head_d = in_data_in;
            end else begin
                tail_d = in_data_in;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            head_q <= '0;
            tail_q <= '0;
            cnt_q  <= 2'h0;
        end else begin
            head_q <= head_d;
            tail_q <= tail_d;
            cnt_q  <= cnt_d;
        end
    end
endmodule

// File: core/lss_ctrl.sv
// Notes on behaviour
// [RULE1] Die samples start inputs on every falling edge
// [RULE2] Launch pulse spans exactly one falling edge
// [RULE3] First active pixel arrives in cycle thirty
// [RULE4] Launch makes all dies preprocess together
// [RULE5] Chain end of one die starts next
// [RULE6] Select high adds 29 inactive pixels, low none
// [RULE7] Chain end aligns with second-to-last active pixel
// [RULE8] Each die outputs 344 active pixels
// [RULE9] Launches spaced by 29 plus 344 per die
// [RULE10] Pixel clock between 500 kHz and 2.5 MHz; a full sample buffer stretches a period with no lower limit
// [RULE11] Pixel clock high for 75 percent; held high longer while the sample buffer is full
// [RULE12] Sample video once per cycle, count position
module lss_ctrl
    import lss_pkg::*;
(
    input  wire logic             core_clk_in,
    input  wire logic             resetn_in,
    lss_link_if.ctrl              link,
    input  wire logic             scan_req_in,
    input  wire logic [DIE_W-1:0] die_count_in,
    output logic                  busy_out,
    output logic                  sample_valid_out,
    input  wire logic             sample_ready_in,
    output logic [DIE_W-1:0]      sample_die_out,
    output logic [PIX_W-1:0]      sample_pixel_out,
    output logic [VID_W-1:0]      sample_level_out
);
    // Pixel clock divider
    logic [PH_W-1:0]  ph_q,     ph_d;
    logic             pclk_q,   pclk_d;

    // Scan bookkeeping
    logic             launch_q, launch_d;
    logic             scan_q,   scan_d;
    logic [CYC_W-1:0] cyc_q,    cyc_d;
    logic [PIX_W-1:0] pix_q,    pix_d;
    logic [DIE_W-1:0] die_q,    die_d;
    logic [DIE_W-1:0] dies_q,   dies_d;

    // Sample path
    logic             fall_now;
    logic             rise_now;
    logic             sample_due;
    logic             hold;
    logic             push;
    logic             buf_ready;
    logic [SMP_W-1:0] push_word;
    logic [SMP_W-1:0] pop_word;

    // Video is taken late in the high phase, well after the die updated it
    assign sample_due = scan_q && (cyc_q == CYC_ACTIVE) && (ph_q == PH_SAMPLE); // RULE12 RULE3
    assign push       = sample_due && buf_ready;

    // A full buffer freezes the pixel clock high; a slower clock is tolerated
    assign hold       = sample_due && !buf_ready;
    assign push_word  = {die_q, pix_q, link.video};

    always_comb begin
        if (hold) begin
            ph_d = ph_q;
        end else if (ph_q == PH_LAST) begin
            ph_d = PH_ZERO;
        end else begin
            ph_d = ph_q + 2'h1;
        end
        pclk_d   = (ph_d < PH_HIGH_END); // RULE11 RULE10
        fall_now = pclk_q && !pclk_d;
        rise_now = !pclk_q && pclk_d;
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            ph_q   <= PH_LAST;
            pclk_q <= 1'b0;
        end else begin
            ph_q   <= ph_d;
            pclk_q <= pclk_d;
        end
    end

    always_comb begin
        launch_d = launch_q;
        scan_d   = scan_q;
        cyc_d    = cyc_q;
        pix_d    = pix_q;
        die_d    = die_q;
        dies_d   = dies_q;
        if (rise_now) begin
            // Raised and dropped on rising edges, so exactly one fall sees it
            if (launch_q) begin
                launch_d = 1'b0; // RULE2
            end else if (scan_req_in && !scan_q) begin
                // A new launch waits for the whole chain, which keeps the spacing
                launch_d = 1'b1; // RULE9
                scan_d   = 1'b1;
                cyc_d    = CYC_ZERO;
                pix_d    = PIX_ZERO;
                die_d    = DIE_ZERO;
                dies_d   = (die_count_in == DIE_ZERO) ? DIE_ONE : die_count_in;
            end
        end
        if (fall_now && scan_q && cyc_q != CYC_ACTIVE) begin
            cyc_d = cyc_q + CYC_ONE; // RULE4
        end
        if (push) begin
            if (pix_q == PIX_LAST) begin // RULE8
                pix_d = PIX_ZERO;
                die_d = die_q + DIE_ONE; // RULE5
                if (die_q + DIE_ONE == dies_q) begin
                    scan_d = 1'b0;
                end
            end else begin
                pix_d = pix_q + PIX_ONE;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            launch_q <= 1'b0;
            scan_q   <= 1'b0;
            cyc_q    <= CYC_ZERO;
            pix_q    <= PIX_ZERO;
            die_q    <= DIE_ZERO;
            dies_q   <= DIE_ONE;
        end else begin
            launch_q <= launch_d;
            scan_q   <= scan_d;
            cyc_q    <= cyc_d;
            pix_q    <= pix_d;
            die_q    <= die_d;
            dies_q   <= dies_d;
        end
    end

    lss_buf2 #(
        .W (SMP_W)
    ) u_buf (
        .core_clk_in   (core_clk_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (push),
        .in_ready_out  (buf_ready),
        .in_data_in    (push_word),
        .out_valid_out (sample_valid_out),
        .out_ready_in  (sample_ready_in),
        .out_data_out  (pop_word)
    );

    assign sample_die_out   = pop_word[SMP_W-1 -: DIE_W];
    assign sample_pixel_out = pop_word[VID_W +: PIX_W];
    assign sample_level_out = pop_word[VID_W-1:0];
    assign busy_out         = scan_q;
    assign link.pix_clk     = pclk_q;
    assign link.launch      = launch_q;
endmodule

// File: core/lss_die.sv
module lss_die
    import lss_pkg::*;
(
    input  wire logic             core_clk_in,
    input  wire logic             resetn_in,
    lss_link_if.die               link,
    input  wire logic             first_die_select_in,
    input  wire logic             chain_start_in,
    input  wire logic [VID_W-1:0] pixel_level_in,
    output logic                  chain_end_out,
    output logic                  scanning_out
);
    lss_die_state_t   state_q, state_d;
    logic [CYC_W-1:0] prep_q,  prep_d;
    logic [PIX_W-1:0] pix_q,   pix_d;
    logic             pclk_q;
    logic             end_q,   end_d;
    logic [VID_W-1:0] vid_q,   vid_d;
    logic             oe_q,    oe_d;
    logic             fall;

    // The die has no timing of its own: everything moves on pixel clock falls
    assign fall = pclk_q & ~link.pix_clk;

    always_comb begin
        state_d = state_q;
        prep_d  = prep_q;
        pix_d   = pix_q;
        if (fall) begin
            // Start inputs are looked at on every fall, so a long launch restarts
            if (link.launch) begin // RULE1
                state_d = LSS_PREP; // RULE4
                prep_d  = CYC_ZERO;
            end else if (chain_start_in) begin // RULE5
                state_d = LSS_ARMED;
            end else begin
                case (state_q)
                    LSS_PREP: begin
                        if (prep_q == CYC_PREP_END) begin
                            // Only the first die runs straight on after preprocessing
                            state_d = first_die_select_in ? LSS_ACTIVE : LSS_IDLE; // RULE6 RULE3
                            pix_d   = PIX_ZERO;
                        end else begin
                            prep_d = prep_q + CYC_ONE;
                        end
                    end
                    LSS_ARMED: begin
                        state_d = LSS_ACTIVE;
                        pix_d   = PIX_ZERO;
                    end
                    LSS_ACTIVE: begin
                        if (pix_q == PIX_LAST) begin // RULE8
                            state_d = LSS_IDLE;
                        end else begin
                            pix_d = pix_q + PIX_ONE;
                        end
                    end
                    default: begin
                        state_d = LSS_IDLE;
                    end
                endcase
            end
        end
        end_d = end_q;
        vid_d = vid_q;
        oe_d  = oe_q;
        if (fall) begin
            // Hand-over fires one pixel early so the next die follows without a gap
            end_d = (state_d == LSS_ACTIVE) && (pix_d == PIX_CHAIN); // RULE7
            oe_d  = (state_d == LSS_ACTIVE);
            vid_d = (state_d == LSS_ACTIVE) ? pixel_level_in : VID_ZERO;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state_q <= LSS_IDLE;
            prep_q  <= CYC_ZERO;
            pix_q   <= PIX_ZERO;
            pclk_q  <= 1'b0;
            end_q   <= 1'b0;
            vid_q   <= VID_ZERO;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            prep_q  <= prep_d;
            pix_q   <= pix_d;
            pclk_q  <= link.pix_clk;
            end_q   <= end_d;
            vid_q   <= vid_d;
            oe_q    <= oe_d;
        end
    end

    assign link.video    = vid_q;
    assign link.video_oe = oe_q;
    assign chain_end_out = end_q;
    assign scanning_out  = (state_q != LSS_IDLE);
endmodule

// File: core/lss_link_if.sv
interface lss_link_if;
    import lss_pkg::*;

    logic             pix_clk;
    logic             launch;
    logic [VID_W-1:0] video;
    logic             video_oe;

    modport ctrl (
        output pix_clk,
        output launch,
        input  video,
        input  video_oe
    );

    modport die (
        input  pix_clk,
        input  launch,
        output video,
        output video_oe
    );
endinterface

// File: core/lss_pkg.sv
package lss_pkg;

    // Core clock and pixel clock timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int PIX_PERIOD_NS  = 400;
    localparam int PIX_HIGH_PCT   = 75;
    localparam int PIX_CYC        = PIX_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PIX_HIGH_CYC   = (PIX_CYC * PIX_HIGH_PCT) / 100;

    // Scan geometry
    localparam int PREP_CYCLES        = 29;
    localparam int FIRST_ACTIVE_CYCLE = PREP_CYCLES + 1;
    localparam int ACTIVE_PIXELS      = 344;
    localparam int CHAIN_END_PIXEL    = ACTIVE_PIXELS - 2;

    // Widths
    localparam int PH_W   = 2;
    localparam int CYC_W  = 5;
    localparam int PIX_W  = 9;
    localparam int DIE_W  = 4;
    localparam int VID_W  = 8;
    localparam int SMP_W  = DIE_W + PIX_W + VID_W;

    // Typed constants for the logic
    localparam logic [PH_W-1:0]  PH_ZERO      = 2'h0;
    localparam logic [PH_W-1:0]  PH_LAST      = PH_W'(PIX_CYC - 1);
    localparam logic [PH_W-1:0]  PH_HIGH_END  = PH_W'(PIX_HIGH_CYC);
    localparam logic [PH_W-1:0]  PH_SAMPLE    = PH_W'(PIX_HIGH_CYC - 1);
    localparam logic [CYC_W-1:0] CYC_ZERO     = 5'h00;
    localparam logic [CYC_W-1:0] CYC_ONE      = 5'h01;
    localparam logic [CYC_W-1:0] CYC_PREP_END = CYC_W'(PREP_CYCLES - 1);
    localparam logic [CYC_W-1:0] CYC_ACTIVE   = CYC_W'(FIRST_ACTIVE_CYCLE);
    localparam logic [PIX_W-1:0] PIX_ZERO     = 9'h000;
    localparam logic [PIX_W-1:0] PIX_ONE      = 9'h001;
    localparam logic [PIX_W-1:0] PIX_LAST     = PIX_W'(ACTIVE_PIXELS - 1);
    localparam logic [PIX_W-1:0] PIX_CHAIN    = PIX_W'(CHAIN_END_PIXEL);
    localparam logic [DIE_W-1:0] DIE_ZERO     = 4'h0;
    localparam logic [DIE_W-1:0] DIE_ONE      = 4'h1;
    localparam logic [VID_W-1:0] VID_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        LSS_IDLE   = 2'b00,
        LSS_PREP   = 2'b01,
        LSS_ARMED  = 2'b10,
        LSS_ACTIVE = 2'b11
    } lss_die_state_t;

endpackage

// File: sim/linear_sensor_scan_sequencer_tb.sv
module linear_sensor_scan_sequencer_tb
    import lss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             core_clk_in;
    logic             resetn_in;
    logic             scan_req;
    logic             ready;
    logic [VID_W-1:0] lvl0;
    logic [VID_W-1:0] lvl1;
    logic             busy;
    logic             s_valid;
    logic [DIE_W-1:0] s_die;
    logic [PIX_W-1:0] s_pix;
    logic [VID_W-1:0] s_lvl;
    logic             end0;
    logic             scan0;
    logic             scan1;
    logic [VID_W-1:0] lv [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
    int               mismatches;
    int               comparisons;
    int               n;
    lss_link_if link_a ();
    lss_link_if link_b ();
    lss_link_if link_c ();
    assign link_b.pix_clk  = link_a.pix_clk;
    assign link_b.launch   = link_a.launch;
    assign link_c.pix_clk  = link_a.pix_clk;
    assign link_c.launch   = link_a.launch;
    // Shared video line: the die with its output enabled owns it
    assign link_a.video_oe = link_b.video_oe | link_c.video_oe;
    assign link_a.video    = link_b.video_oe ? link_b.video : link_c.video;
    lss_ctrl lss_ctrl_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .link(link_a.ctrl), .scan_req_in(scan_req), .die_count_in(4'h2), .busy_out(busy),
        .sample_valid_out(s_valid), .sample_ready_in(ready), .sample_die_out(s_die),
        .sample_pixel_out(s_pix), .sample_level_out(s_lvl));
    lss_die lss_die_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .link(link_b.die), .first_die_select_in(1'b1), .chain_start_in(1'b0),
        .pixel_level_in(lvl0), .chain_end_out(end0), .scanning_out(scan0));
    lss_die lss_die_inst_b (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .link(link_c.die), .first_die_select_in(1'b0), .chain_start_in(end0),
        .pixel_level_in(lvl1), .chain_end_out(), .scanning_out(scan1));
    lss_checker lss_checker_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .pix_clk(link_a.pix_clk), .launch(link_a.launch), .video(link_a.video),
        .video_oe(link_a.video_oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic read_word(input int i, input int s);
        int k;
        k = 0;
        do begin
            @(negedge core_clk_in);
            k++;
        end while (!(s_valid === 1'b1 && ready === 1'b1) && k < 1000);
        if (k >= 1000) begin
            mismatches++;
            end_sim();
        end
        check(s_die, i / ACTIVE_PIXELS);
        check(s_pix, i % ACTIVE_PIXELS);
        check(s_lvl, lv[2 * s + i / ACTIVE_PIXELS]);
        @(posedge core_clk_in);
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    initial begin
        resetn_in   = 1'b0;
        scan_req    = 1'b0;
        ready       = 1'b1;
        lvl0        = 8'h00;
        lvl1        = 8'h00;
        mismatches  = 0;
        comparisons = 0;
        repeat (20) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        scan_req  <= 1'b1;
        // Request stays high over the first scan to exercise the spacing guard
        for (int s = 0; s < 2; s++) begin
            lvl0 <= lv[2 * s];
            lvl1 <= lv[2 * s + 1];
            for (int i = 0; i < 2 * ACTIVE_PIXELS; i++) begin
                if (i % 300 == 100) begin
                    ready <= 1'b0;
                    repeat (40) @(posedge core_clk_in);
                    ready <= 1'b1;
                end
                read_word(i, s);
                scan_req <= (s == 0);
                if (i == 0) begin
                    check(busy, 1'b1);
                    check(scan0, 1'b1);
                    check(scan1, 1'b0);
                end
            end
        end
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (busy !== 1'b0 && n < 200);
        check(busy, 1'b0);
        check(scan0, 1'b0);
        check(scan1, 1'b0);
        repeat (100) @(negedge core_clk_in);
        check(link_a.launch, 1'b0);
        end_sim();
    end
endmodule

// File: sim/lss_checker.sv
module lss_checker
    import lss_pkg::*;
(
    input  wire logic             core_clk_in,
    input  wire logic             resetn_in,
    input  wire logic             pix_clk,
    input  wire logic             launch,
    input  wire logic [VID_W-1:0] video,
    input  wire logic             video_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       pix_q;
    logic       fell;
    logic [9:0] fall_q;
    logic [9:0] run_q;
    // Same fall detection as the die, so counts line up with its updates
    assign fell = pix_q && !pix_clk;
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            pix_q  <= 1'b0;
            fall_q <= 10'h3ff;
            run_q  <= 10'h000;
        end else begin
            pix_q <= pix_clk;
            if (fell && launch) begin
                fall_q <= 10'h000;
            end else if (fell && fall_q != 10'h3ff) begin
                fall_q <= fall_q + 10'h001;
            end
            if (!video_oe) begin
                run_q <= 10'h000;
            end else if (fell) begin
                run_q <= run_q + 10'h001;
            end
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_launch_fall;
        fell && launch;
    endsequence
    sequence s_one_period;
        launch[*4] ##1 !launch;
    endsequence
    a_clk_low_one: assert property ($fell(pix_clk) |=> pix_clk)
        else $error("pixel clock low too long");
    a_clk_high_min: assert property ($rose(pix_clk) |-> pix_clk[*3])
        else $error("pixel clock high too short");
    a_launch_width: assert property ($rose(launch) |-> s_one_period)
        else $error("launch not one pixel period");
    a_launch_on_rise: assert property ($rose(launch) |-> $rose(pix_clk))
        else $error("launch off the pixel clock rise");
    a_launch_spacing: assert property (s_launch_fall |-> fall_q >= 10'h2cc)
        else $error("launches too close");
    a_first_pixel: assert property ($rose(video_oe) |-> fall_q == 10'h01d)
        else $error("first pixel in wrong cycle");
    a_active_run: assert property ($fell(video_oe) |-> run_q == 10'h2b0)
        else $error("wrong active pixel count");
    a_idle_zero: assert property (!video_oe |-> video == VID_ZERO)
        else $error("video not zero when idle");
    a_change_on_fall: assert property ($changed({video_oe, video}) |-> $past(fell))
        else $error("video changed off a fall");
endmodule
